// File: logic/pot_div.sv
/*
 Iterative unsigned divider, one quotient bit per clock.
 Assumes a nonzero divisor and start only while not busy.
*/
`timescale 1ns/1ps
module pot_div #(
  parameter int NW = 64,
  parameter int DW = 40
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // Answer
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quot
);
  import pot_pkg::*;

  generate
    if (DW > NW) begin : g_bad
      $error("pot_div: divisor wider than dividend");
    end
  endgenerate

  logic [DW:0]          rem_q;
  logic [NW-1:0]        q_q;
  logic [NW-1:0]        n_q;
  logic [DW-1:0]        d_q;
  logic [$clog2(NW):0]  cnt_q;
  logic                 done_q;
  wire  [DW:0]          trial = {rem_q[DW-1:0], n_q[NW-1]};
  wire                  fits  = trial >= {1'b0, d_q};

  assign busy = cnt_q != '0;
  assign done = done_q;
  assign quot = q_q;

  // ========================================================================
  // Shift and subtract
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q  <= '0;
      q_q    <= '0;
      n_q    <= '0;
      d_q    <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy) begin
        rem_q <= '0;
        n_q   <= num;
        d_q   <= den;
        cnt_q <= ($clog2(NW)+1)'(NW);
      end else if (busy) begin
        rem_q  <= fits ? trial - {1'b0, d_q} : trial;
        q_q    <= {q_q[NW-2:0], fits};
        n_q    <= {n_q[NW-2:0], 1'b0};
        cnt_q  <= cnt_q - 1'b1;
        done_q <= cnt_q == 1;
      end
    end
  end
endmodule // pot_div

// File: logic/pot_gen.sv
/*
 Pulse waveform generator on a ns phase accumulator.
 Assumes period above one clock step and width below period.
*/
`timescale 1ns/1ps
module pot_gen (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Timing
  input  wire logic                enable,
  input  wire pot_pkg::pot_timing_t timing,
  // Output
  output logic                     pulse_out
);
  import pot_pkg::*;

  logic [39:0] phase_q;
  logic        out_q;
  wire  [39:0] step  = phase_q + `POT_CLK_NS;
  wire         wrap  = step >= timing.period;
  wire  [39:0] phase_d = !enable ? 40'h0000000000 :
                         wrap ? step - timing.period : step;

  assign pulse_out = out_q;

  // ========================================================================
  // High while phase below width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= '0;
      out_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      out_q   <= enable && (phase_d < timing.width);
    end
  end
endmodule // pot_gen

// File: logic/pot_params.svh
/*
 Register offsets, reset values and limits for the pulse output timing block.
 Assumes inclusion by bare name from the package, the checker and the bench.
*/
`ifndef POT_PARAMS_SVH
`define POT_PARAMS_SVH

// ==========================================================================
// Register offsets
`define POT_CTRL_OFS      8'h00
`define POT_STAGE_OFS     8'h04
`define POT_PER_LO_OFS    8'h08
`define POT_PER_HI_OFS    8'h0C
`define POT_WID_LO_OFS    8'h10
`define POT_WID_HI_OFS    8'h14
`define POT_FRQ_LO_OFS    8'h18
`define POT_FRQ_HI_OFS    8'h1C
`define POT_DUTY_OFS      8'h20
`define POT_DMIN_OFS      8'h24
`define POT_DMAX_OFS      8'h28

// ==========================================================================
// Field positions
`define POT_CTRL_VIEW_BIT  0
`define POT_CTRL_CODED_BIT 1
`define POT_CTRL_BUSY_BIT  2
`define POT_CTRL_DMODE_BIT 3
`define POT_STAGE_KEY_LSB  8

// ==========================================================================
// Times in ns, frequency in mHz, duty in 0.01 %
`define POT_CLK_NS        40'h000000000A
`define POT_WIDTH_MIN_NS  40'h0000000005
`define POT_PERIOD_MIN_NS 40'h0000000028
`define POT_PERIOD_MAX_NS 40'hE8D4A51000
`define POT_PERIOD_RST_NS 40'h003B9ACA00
`define POT_WIDTH_RST_NS  40'h001DCD6500
`define POT_NS_MHZ        64'h000000E8D4A51000
`define POT_FREQ_MIN_MHZ  36'h000000001
`define POT_FREQ_MAX_MHZ  36'h5D21DBA00
`define POT_FREQ_RST_MHZ  36'h0000003E8
`define POT_DUTY_FULL     14'h2710
`define POT_DUTY_RST      14'h1388
`define POT_DMIN_RST      14'h0001
`define POT_DMAX_RST      14'h270F

`endif

// File: logic/pot_pkg.sv
/*
 Types shared by the pulse output timing block.
 Assumes pot_params.svh is on the include path.
*/
package pot_pkg;
  `include "pot_params.svh"

  // ========================================================================
  // Value keyword carried with every committed setting
  typedef enum logic [1:0] {
    POT_KEY_VALUE = 2'h0,
    POT_KEY_MIN   = 2'h1,
    POT_KEY_MAX   = 2'h2,
    POT_KEY_DEF   = 2'h3
  } pot_key_t;

  // ========================================================================
  // Sequencer states, Gray from IDLE through FREQ, WID and STAT to MIN
  typedef enum logic [2:0] {
    POT_ST_IDLE = 3'h0,
    POT_ST_FREQ = 3'h1,
    POT_ST_WID  = 3'h3,
    POT_ST_STAT = 3'h2,
    POT_ST_MIN  = 3'h6
  } pot_state_t;

  // ========================================================================
  // Applied timing
  typedef struct packed {
    logic [39:0] period;
    logic [39:0] width;
  } pot_timing_t;
endpackage

// File: logic/pot_top.sv
/*
 Pulse output timing block: APB registers, setting sequencer and generator.
 Assumes an APB master on pclk and a coded time generator elsewhere.
*/
`timescale 1ns/1ps
module pot_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Output side
  output logic             pulse_out,
  output logic             coded_sel,
  output logic             view_sel
);
  import pot_pkg::*;

  localparam int NW = 64;

  // ========================================================================
  // State
  pot_state_t     st_q;
  pot_timing_t    tm_q;
  logic [35:0]    freq_q;
  logic [13:0]    duty_q;
  logic [13:0]    dmin_q;
  logic           duty_mode_q;
  logic           view_q;
  logic           coded_q;
  logic [7:0]     stage_hi_q;
  pot_key_t       stage_key_q;
  logic           issued_q;
  logic [31:0]    prdata_q;
  logic           slverr_q;
  logic           settle_q;

  // ========================================================================
  // Helpers
  function automatic logic [39:0] clamp_w(input logic [39:0] w, input logic [39:0] p);
    logic [39:0] top;
    top = p - `POT_WIDTH_MIN_NS;
    if (w < `POT_WIDTH_MIN_NS) begin
      clamp_w = `POT_WIDTH_MIN_NS;
    end else if (w > top) begin
      clamp_w = top;
    end else begin
      clamp_w = w;
    end
  endfunction

  function automatic logic [39:0] clamp_p(input logic [39:0] p);
    if (p < `POT_PERIOD_MIN_NS) begin
      clamp_p = `POT_PERIOD_MIN_NS;
    end else if (p > `POT_PERIOD_MAX_NS) begin
      clamp_p = `POT_PERIOD_MAX_NS;
    end else begin
      clamp_p = p;
    end
  endfunction

  // ========================================================================
  // Bus decode
  wire         busy     = st_q != POT_ST_IDLE;
  wire         acc      = psel && penable && pready;
  wire         wr       = acc && pwrite;
  wire         hit_ctrl = paddr == `POT_CTRL_OFS;
  wire         hit_stg  = paddr == `POT_STAGE_OFS;
  wire         hit_per  = paddr == `POT_PER_LO_OFS;
  wire         hit_wid  = paddr == `POT_WID_LO_OFS;
  wire         hit_frq  = paddr == `POT_FRQ_LO_OFS;
  wire         hit_duty = paddr == `POT_DUTY_OFS;
  wire         hit_set  = hit_per || hit_wid || hit_frq || hit_duty;
  wire         hit_ro   = paddr == `POT_PER_HI_OFS || paddr == `POT_WID_HI_OFS ||
                          paddr == `POT_FRQ_HI_OFS || paddr == `POT_DMIN_OFS ||
                          paddr == `POT_DMAX_OFS;
  wire         mapped   = hit_ctrl || hit_stg || hit_set || hit_ro;
  wire         set_bad  = pwrite && hit_set && coded_q;
  wire         err      = !mapped || (pwrite && hit_ro) || set_bad;
  wire         wr_ok    = wr && !err;
  wire [39:0]  val40    = {stage_hi_q, pwdata};
  wire [35:0]  val36    = {stage_hi_q[3:0], pwdata};
  wire [13:0]  dmax     = `POT_DUTY_FULL - dmin_q;
  assign pready = !busy && !settle_q;  // One idle cycle so read data is fresh

  // ========================================================================
  // Commit values per keyword
  logic [39:0] per_new;
  logic [39:0] wid_new;
  logic [35:0] frq_new;
  logic [13:0] duty_new;

  always_comb begin
    case (stage_key_q)
      POT_KEY_MIN: begin
        per_new  = `POT_PERIOD_MIN_NS;
        wid_new  = `POT_WIDTH_MIN_NS;
        frq_new  = `POT_FREQ_MIN_MHZ;
        duty_new = dmin_q;
      end
      POT_KEY_MAX: begin
        per_new  = `POT_PERIOD_MAX_NS;
        wid_new  = tm_q.period - `POT_WIDTH_MIN_NS;
        frq_new  = `POT_FREQ_MAX_MHZ;
        duty_new = dmax;
      end
      POT_KEY_DEF: begin
        per_new  = `POT_PERIOD_RST_NS;
        wid_new  = {1'b0, tm_q.period[39:1]};
        frq_new  = `POT_FREQ_RST_MHZ;
        duty_new = `POT_DUTY_RST;
      end
      default: begin
        per_new  = clamp_p(val40);
        wid_new  = val40;
        frq_new  = val36 < `POT_FREQ_MIN_MHZ ? `POT_FREQ_MIN_MHZ :
                   val36 > `POT_FREQ_MAX_MHZ ? `POT_FREQ_MAX_MHZ : val36;
        duty_new = pwdata[13:0] > `POT_DUTY_FULL ? `POT_DUTY_FULL :
                   pwdata[13:0];
      end
    endcase
  end

  // ========================================================================
  // Divider operands per state
  logic [NW-1:0] div_num;
  logic [39:0]   div_den;
  logic [NW-1:0] div_q;
  logic          div_busy;
  logic          div_done;

  wire [NW-1:0] prod_pd = NW'(tm_q.period * duty_q);
  wire [NW-1:0] prod_wd = NW'(tm_q.width * `POT_DUTY_FULL);
  wire [NW-1:0] min_num = NW'(`POT_WIDTH_MIN_NS * `POT_DUTY_FULL) +
                          NW'(tm_q.period) - NW'(1);

  always_comb begin
    case (st_q)
      POT_ST_FREQ: begin
        div_num = `POT_NS_MHZ;
        div_den = {4'h0, freq_q};
      end
      POT_ST_WID: begin
        div_num = prod_pd;
        div_den = {26'h0, `POT_DUTY_FULL};
      end
      POT_ST_MIN: begin
        div_num = min_num;
        div_den = tm_q.period;
      end
      default: begin
        div_num = prod_wd;
        div_den = tm_q.period;
      end
    endcase
  end

  wire need_div  = st_q == POT_ST_FREQ || st_q == POT_ST_STAT || st_q == POT_ST_MIN ||
                   (st_q == POT_ST_WID && duty_mode_q);
  wire div_start = need_div && !issued_q && !div_busy;

  pot_div #(
    .NW (NW),
    .DW (40)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_q)
  );

  // ========================================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= POT_ST_IDLE;
      tm_q        <= '{period: `POT_PERIOD_RST_NS, width: `POT_WIDTH_RST_NS};
      freq_q      <= `POT_FREQ_RST_MHZ;
      duty_q      <= `POT_DUTY_RST;
      dmin_q      <= `POT_DMIN_RST;
      duty_mode_q <= 1'b1;
      issued_q    <= 1'b0;
      settle_q    <= 1'b0;
    end else begin
      settle_q <= busy;
      if (div_start) begin
        issued_q <= 1'b1;
      end else if (div_done) begin
        issued_q <= 1'b0;
      end
      case (st_q)
        POT_ST_IDLE: begin
          if (wr_ok && hit_per) begin
            tm_q.period <= per_new;
            st_q        <= POT_ST_WID;
          end else if (wr_ok && hit_frq) begin
            freq_q <= frq_new;
            st_q   <= POT_ST_FREQ;
          end else if (wr_ok && hit_wid) begin
            duty_mode_q <= 1'b0;
            tm_q.width  <= clamp_w(wid_new, tm_q.period);
            st_q        <= POT_ST_STAT;
          end else if (wr_ok && hit_duty) begin
            duty_mode_q <= 1'b1;
            duty_q      <= duty_new;
            st_q        <= POT_ST_WID;
          end
        end
        POT_ST_FREQ: begin
          if (div_done) begin
            tm_q.period <= clamp_p(div_q[39:0]);
            st_q        <= POT_ST_WID;
          end
        end
        POT_ST_WID: begin
          if (!duty_mode_q) begin
            tm_q.width <= clamp_w(tm_q.width, tm_q.period);
            st_q       <= POT_ST_STAT;
          end else if (div_done) begin
            tm_q.width <= clamp_w(div_q[39:0], tm_q.period);
            st_q       <= POT_ST_STAT;
          end
        end
        POT_ST_STAT: begin
          if (div_done) begin
            if (!duty_mode_q) begin
              duty_q <= div_q[13:0];
            end
            st_q <= POT_ST_MIN;
          end
        end
        POT_ST_MIN: begin
          if (div_done) begin
            dmin_q <= div_q[13:0];
            st_q   <= POT_ST_IDLE;
          end
        end
        default: begin
          st_q <= POT_ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Control and staging registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      view_q      <= 1'b0;
      coded_q     <= 1'b0;
      stage_hi_q  <= '0;
      stage_key_q <= POT_KEY_VALUE;
    end else begin
      if (wr_ok && hit_ctrl) begin
        view_q  <= pwdata[`POT_CTRL_VIEW_BIT];
        coded_q <= pwdata[`POT_CTRL_CODED_BIT];
      end
      if (wr_ok && hit_stg) begin
        stage_hi_q  <= pwdata[7:0];
        stage_key_q <= pot_key_t'(pwdata[`POT_STAGE_KEY_LSB +: 2]);
      end else if (wr_ok && hit_set) begin
        stage_key_q <= POT_KEY_VALUE;
      end
    end
  end

  // ========================================================================
  // Read data
  logic [31:0] rd_data;

  always_comb begin
    case (paddr)
      `POT_CTRL_OFS:   rd_data = {28'h0, duty_mode_q, busy, coded_q, view_q};
      `POT_STAGE_OFS:  rd_data = {22'h0, stage_key_q, stage_hi_q};
      `POT_PER_LO_OFS: rd_data = tm_q.period[31:0];
      `POT_PER_HI_OFS: rd_data = {24'h0, tm_q.period[39:32]};
      `POT_WID_LO_OFS: rd_data = tm_q.width[31:0];
      `POT_WID_HI_OFS: rd_data = {24'h0, tm_q.width[39:32]};
      `POT_FRQ_LO_OFS: rd_data = freq_q[31:0];
      `POT_FRQ_HI_OFS: rd_data = {28'h0, freq_q[35:32]};
      `POT_DUTY_OFS:   rd_data = {18'h0, duty_q};
      `POT_DMIN_OFS:   rd_data = {18'h0, dmin_q};
      `POT_DMAX_OFS:   rd_data = {18'h0, dmax};
      default:         rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (psel) begin
      prdata_q <= rd_data;
      slverr_q <= err;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = slverr_q && psel && penable && pready;

  // ========================================================================
  // Waveform
  pot_gen u_gen (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (!coded_q),
    .timing    (tm_q),
    .pulse_out (pulse_out)
  );

  assign coded_sel = coded_q;
  assign view_sel  = view_q;
endmodule // pot_top

// File: test/pot_chk.sv
/*
 Port checker for the pulse output timing block.
 Assumes a bind onto every pot_top instance.
*/
`timescale 1ns/1ps
`include "pot_params.svh"
module pot_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Output side
  input wire logic        pulse_out,
  input wire logic        coded_sel,
  input wire logic        view_sel
);
  import pot_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Accepted transfers
  sequence acc_at(logic [7:0] a);
    psel && penable && pready && paddr == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    acc_at(a) ##0 pwrite;
  endsequence

  // ==========================================================================
  // Properties
  err_phase_a: assert property (pslverr |-> psel && penable && pready)
    else $error("error response outside access phase");
  view_wr_a: assert property (
    wr_at(`POT_CTRL_OFS) |=> view_sel == $past(pwdata[0]))
    else $error("view selector not stored");
  coded_wr_a: assert property (
    wr_at(`POT_CTRL_OFS) |=> coded_sel == $past(pwdata[1]))
    else $error("function select not stored");
  coded_ref_a: assert property (
    wr_at(`POT_PER_LO_OFS) ##0 coded_sel |-> pslverr)
    else $error("period write accepted in coded function");
  coded_quiet_a: assert property (coded_sel [*2] |-> !pulse_out)
    else $error("pulse active in coded function");
  ro_ref_a: assert property (wr_at(`POT_DMIN_OFS) |-> pslverr)
    else $error("write to duty limit accepted");
  commit_busy_a: assert property (
    wr_at(`POT_PER_LO_OFS) ##0 !coded_sel |=> !pready)
    else $error("period commit did not recompute");
  busy_end_a: assert property ($fell(pready) |-> ##[1:300] pready)
    else $error("recompute did not finish");
  unmapped_a: assert property (
    psel && penable && pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
endmodule // pot_chk

bind pot_top pot_chk i_chk (
  .pclk      (pclk),
  .presetn   (presetn),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .paddr     (paddr),
  .pwdata    (pwdata),
  .pready    (pready),
  .prdata    (prdata),
  .pslverr   (pslverr),
  .pulse_out (pulse_out),
  .coded_sel (coded_sel),
  .view_sel  (view_sel)
);

// File: test/pulse_output_timing_test.sv
/*
 Self-checking bench for the pulse output timing block over APB.
 Assumes the checker binds itself to the instance.
*/
`timescale 1ns/1ps
`include "pot_params.svh"
module pulse_output_timing_test;
  import pot_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        pulse_out, coded_sel, view_sel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] p, q;
  logic [13:0] d;
  int          i, hi, err_total, n_compared;
  localparam logic [39:0] FQ [4] = '{40'h00000003E8, 40'h00000F4240,
                                     40'h009502F900, 40'h05D21DBA00};
  localparam logic [39:0] PQ [4] = '{40'h003B9ACA00, 40'h00000F4240,
                                     40'h0000000190, 40'h0000000028};

  pot_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pulse_out(pulse_out),
    .coded_sel(coded_sel), .view_sel(view_sel));

  always #5 pclk = ~pclk;

  // ==========================================================================
  // Helpers
  task automatic final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] dat);
    int  n;
    logic rdy;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    rdy = 1'b0;
    for (n = 0; n < 400 && rdy !== 1'b1; n++) begin
      @(posedge pclk);
      rdy = pready;
      rd  = prdata;
      er  = pslverr;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic rdck(string what, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic rd40(string what, logic [7:0] a, logic [39:0] exp);
    rdck(what, a, exp[31:0]);
    rdck(what, a + 8'h04, {24'h0, exp[39:32]});
  endtask

  task automatic set(logic [7:0] a, logic [39:0] v, logic [1:0] key);
    apb(1'b1, `POT_STAGE_OFS, {22'h0, key, v[39:32]});
    apb(1'b1, a, v[31:0]);
  endtask

  task automatic hcount(int n);
    hi = 0;
    repeat (20) @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      hi += (pulse_out === 1'b1);
    end
  endtask

  function automatic logic [39:0] cl(logic [39:0] per, logic [63:0] w);
    if (w < 64'd5) w = 64'd5;
    if (w > per - 40'd5) w = per - 40'd5;
    return w[39:0];
  endfunction

  function automatic logic [39:0] dw(logic [39:0] per, logic [13:0] du);
    logic [63:0] w;
    w = per * du / 64'd10000;
    return cl(per, w);
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'h8B67));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd40("period", `POT_PER_LO_OFS, 40'h003B9ACA00);
    rd40("width", `POT_WID_LO_OFS, 40'h001DCD6500);
    rdck("duty", `POT_DUTY_OFS, 32'h1388);
    rdck("ctrl", `POT_CTRL_OFS, 32'h8);
    apb(1'b1, `POT_CTRL_OFS, 32'h1);
    @(negedge pclk);
    check("view_sel", view_sel, 1);
    rdck("ctrl", `POT_CTRL_OFS, 32'h9);
    apb(1'b1, `POT_CTRL_OFS, 32'h0);
    for (i = 0; i < 6; i++) begin
      p = 40 + $urandom % 2000000;
      q = 40 + $urandom % 50000;
      d = (i == 0) ? 14'h0 : (i == 1) ? 14'h2710 : 14'($urandom % 10001);
      set(`POT_PER_LO_OFS, p, 2'h0);
      apb(1'b1, `POT_DUTY_OFS, {18'h0, d});
      rd40("width", `POT_WID_LO_OFS, dw(p, d));
      set(`POT_PER_LO_OFS, q, 2'h0);
      rd40("width", `POT_WID_LO_OFS, dw(q, d));
      rdck("duty", `POT_DUTY_OFS, {18'h0, d});
    end
    rdck("dmin", `POT_DMIN_OFS, 32'((50000 + q - 1) / q));
    rdck("dmax", `POT_DMAX_OFS, 32'(10000 - (50000 + q - 1) / q));
    set(`POT_PER_LO_OFS, 40'd1000, 2'h0);
    set(`POT_WID_LO_OFS, 40'd300, 2'h0);
    rdck("ctrl", `POT_CTRL_OFS, 32'h0);
    set(`POT_PER_LO_OFS, 40'd400, 2'h0);
    rd40("width", `POT_WID_LO_OFS, 40'd300);
    set(`POT_PER_LO_OFS, 40'd100, 2'h0);
    rd40("width", `POT_WID_LO_OFS, 40'd95);
    set(`POT_WID_LO_OFS, 40'd1, 2'h0);
    rd40("width", `POT_WID_LO_OFS, 40'd5);
    set(`POT_WID_LO_OFS, 40'd30, 2'h0);
    hcount(100);
    check("high", hi, 30);
    set(`POT_PER_LO_OFS, 40'h0, 2'h1);
    rd40("period", `POT_PER_LO_OFS, 40'h0000000028);
    set(`POT_PER_LO_OFS, 40'h0, 2'h2);
    rd40("period", `POT_PER_LO_OFS, 40'hE8D4A51000);
    set(`POT_PER_LO_OFS, 40'h0, 2'h3);
    rd40("period", `POT_PER_LO_OFS, 40'h003B9ACA00);
    rdck("ctrl", `POT_CTRL_OFS, 32'h0);
    set(`POT_WID_LO_OFS, 40'h0, 2'h3);
    rd40("width", `POT_WID_LO_OFS, 40'h001DCD6500);
    set(`POT_WID_LO_OFS, 40'h0, 2'h2);
    rd40("width", `POT_WID_LO_OFS, 40'h003B9AC9FB);
    set(`POT_DUTY_OFS, 40'h0, 2'h1);
    rdck("duty", `POT_DUTY_OFS, 32'h1);
    set(`POT_DUTY_OFS, 40'h0, 2'h3);
    rd40("width", `POT_WID_LO_OFS, 40'h001DCD6500);
    rdck("ctrl", `POT_CTRL_OFS, 32'h8);
    for (i = 0; i < 4; i++) begin
      set(`POT_FRQ_LO_OFS, FQ[i], 2'h0);
      rd40("period", `POT_PER_LO_OFS, PQ[i]);
      rd40("freq", `POT_FRQ_LO_OFS, FQ[i]);
    end
    apb(1'b1, `POT_CTRL_OFS, 32'h2);
    @(negedge pclk);
    check("coded_sel", coded_sel, 1);
    set(`POT_PER_LO_OFS, 40'd1000, 2'h0);
    check("refused", er, 1);
    rd40("period", `POT_PER_LO_OFS, 40'h0000000028);
    hcount(40);
    check("quiet", hi, 0);
    apb(1'b1, `POT_CTRL_OFS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", er, 1);
    apb(1'b1, `POT_DMIN_OFS, 32'h5);
    check("read only", er, 1);
    final_report();
  end
endmodule // pulse_output_timing_test
